// File: rtl/bts_pkg.sv
// package: register map, code ladder and i2c constants for the buck target selector
package bts_pkg;

    localparam logic [6:0]  I2C_DEV_ADDR  = 7'h3C;

    localparam logic [7:0]  OFS_ONE_TGT   = 8'h17;
    localparam logic [7:0]  OFS_ZERO_DVS  = 8'h1B;
    localparam logic [7:0]  OFS_ONE_DVS   = 8'h1C;

    localparam logic [7:0]  RST_ZERO_DVS  = 8'h20;
    localparam logic [7:0]  RST_ONE_DVS   = 8'h10;
    localparam int          OTP_WIDTH     = 5;

    localparam logic [7:0]  ZERO_CODE_MAX = 8'h40;
    localparam logic [7:0]  ONE_CODE_MAX  = 8'h4C;
    localparam logic [7:0]  CODE_FIRST    = 8'h02;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

    localparam int          UV_WIDTH      = 22;
    // 625000 uV at the first valid code, 12500 uV per code
    localparam logic [21:0] UV_AT_FIRST   = 22'h9_8968;
    localparam logic [21:0] UV_STEP       = 22'h30D4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_SUB  = 3'b010,
        ST_WR   = 3'b011,
        ST_RD   = 3'b100
    } bts_i2c_state_type;

    function automatic logic [21:0] bts_code_to_uv(input logic [7:0] code);
        logic [7:0]  steps;
        logic [21:0] wide;
        steps = code - CODE_FIRST;
        wide  = {14'h0, steps};
        return UV_AT_FIRST + 22'(wide * UV_STEP);
    endfunction : bts_code_to_uv

endpackage : bts_pkg

// File: rtl/bts_sel_if.sv
// interface: codes and controls passed between the register bank and one selector
interface bts_sel_if;
    logic [7:0]                 main_code;
    logic [7:0]                 alt_code;
    logic                       alt_enable;
    logic                       polarity;
    logic                       pin_raw;
    logic [7:0]                 target_code;
    logic                       scaling_active;
    logic                       code_reserved;
    logic [bts_pkg::UV_WIDTH-1:0] target_uv;

    modport owner (
        output main_code, alt_code, alt_enable, polarity, pin_raw,
        input  target_code, scaling_active, code_reserved, target_uv
    );
    modport sel (
        input  main_code, alt_code, alt_enable, polarity, pin_raw,
        output target_code, scaling_active, code_reserved, target_uv
    );
endinterface : bts_sel_if

// File: rtl/bts_dvs_select.sv
// module: pin-driven choice between main and scaling code for one regulator
module bts_dvs_select (
    input  wire logic ref_clk,
    input  wire logic reset,
    bts_sel_if.sel    sel
);

    logic [2:0]                   pin_sync_r;
    logic                         pin_level_r;
    logic                         active_nxt;
    logic [7:0]                   code_nxt;
    logic [7:0]                   target_code_r;
    logic                         scaling_active_r;
    logic                         code_reserved_r;
    logic [bts_pkg::UV_WIDTH-1:0] target_uv_r;

    // pin is asynchronous; a level counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], sel.pin_raw};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_level_r <= 1'b0;
        end else if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_level_r <= pin_sync_r[2];
        end
    end

    // polarity 0: high is active, polarity 1: low is active
    assign active_nxt = sel.alt_enable && (pin_level_r ^ sel.polarity);
    assign code_nxt   = active_nxt ? sel.alt_code : sel.main_code;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            target_code_r    <= 8'h00;
            scaling_active_r <= 1'b0;
            code_reserved_r  <= 1'b1;
            target_uv_r      <= 22'h0;
        end else begin
            target_code_r    <= code_nxt;
            scaling_active_r <= active_nxt;
            code_reserved_r  <= code_nxt < bts_pkg::CODE_FIRST;
            target_uv_r      <= (code_nxt < bts_pkg::CODE_FIRST) ? 22'h0
                                : bts_pkg::bts_code_to_uv(code_nxt);
        end
    end

    assign sel.target_code    = target_code_r;
    assign sel.scaling_active = scaling_active_r;
    assign sel.code_reserved  = code_reserved_r;
    assign sel.target_uv      = target_uv_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_alt_code_drives: assert property (
        sel.alt_enable && (pin_level_r ^ sel.polarity)
        |=> scaling_active_r && target_code_r == $past(sel.alt_code)
    ) else $error("scaling code not selected while pin active");

    a_main_code_drives: assert property (
        !(sel.alt_enable && (pin_level_r ^ sel.polarity))
        |=> !scaling_active_r && target_code_r == $past(sel.main_code)
    ) else $error("main code not selected while pin inactive");

    a_enable_gates_pin: assert property (
        !sel.alt_enable [*2] |=> !scaling_active_r
    ) else $error("scaling active without alternate enable");

    a_polarity_sense: assert property (
        (sel.alt_enable && $stable(sel.polarity) && pin_sync_r[1] == pin_sync_r[2]
         && pin_sync_r[2] != sel.polarity) [*2]
        |=> scaling_active_r
    ) else $error("pin level of chosen polarity did not activate scaling");

    a_reserved_flag: assert property (
        code_reserved_r == (target_code_r < 8'h02)
    ) else $error("reserved flag disagrees with code");

    a_uv_ladder: assert property (
        (!code_reserved_r && !$past(code_reserved_r)
         && target_code_r == $past(target_code_r) + 8'h01)
        |-> target_uv_r == $past(target_uv_r) + 22'h30D4
    ) else $error("voltage step between adjacent codes wrong");

    a_uv_first_code: assert property (
        target_code_r == 8'h02 |-> target_uv_r == 22'h9_8968
    ) else $error("first valid code does not give base voltage");

endmodule : bts_dvs_select

// File: rtl/bts_target_select.sv
// top: i2c register bank and scaling target selection for two step-down regulators
// Functional notes
// - register 0x17 holds the second regulator's eight-bit target code, read/write.
// - register 0x1B holds the first regulator's scaling code, reset 0x20.
// - register 0x1C holds the second regulator's scaling code, reset 0x10.
// - the fifth pin steers the first regulator only while its alternate enable is 1.
// - the fifth pin's polarity bit picks whether high or low counts as active.
// - an active fifth pin drives the first regulator from its scaling code.
// - an inactive fifth pin drives the first regulator from its main code.
// - the sixth pin steers the second regulator only while its alternate enable is 1.
// - the sixth pin's polarity bit picks whether high or low counts as active.
// - an active sixth pin drives the second regulator from its scaling code.
// - an inactive sixth pin drives the second regulator from its own code at 0x17.
// - codes step 12.5 mV from 0.6250 V at 0x02, codes 0x00 and 0x01 are reserved.
// - writes of 0x41 to 0xFF to the first regulator's code register are ignored.
// - writes of 0x4D to 0xFF to the second regulator's code registers are ignored.
module bts_target_select #(
    parameter logic [6:0] DEV_ADDR = bts_pkg::I2C_DEV_ADDR
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        global_shutdown,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [4:0]  otp_buck_one_bits,
    input  wire logic [7:0]  buck_zero_target_code,
    input  wire logic        pin_five_alternate_enable,
    input  wire logic        pin_five_polarity_select,
    input  wire logic        pin_six_alternate_enable,
    input  wire logic        pin_six_polarity_select,
    input  wire logic        general_pin_five,
    input  wire logic        general_pin_six,
    output logic [7:0]       buck_zero_active_code,
    output logic [7:0]       buck_one_active_code,
    output logic             buck_zero_scaling_active,
    output logic             buck_one_scaling_active,
    output logic             buck_zero_code_reserved,
    output logic             buck_one_code_reserved,
    output logic [21:0]      buck_zero_target_uv,
    output logic [21:0]      buck_one_target_uv
);

    bts_pkg::bts_i2c_state_type state_r;

    logic [1:0] bus_raw;
    logic [1:0] bus_lvl;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic       rw_r;
    logic       ack_go_r;
    logic       ack_phase_r;
    logic       sda_oe_r;
    logic       sda_out_r;
    logic       wr_en_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic [7:0] buck_one_target_code_r;
    logic [7:0] buck_zero_scaling_code_r;
    logic [7:0] buck_one_scaling_code_r;

    // both bus lines are asynchronous: three stages, change counts when two and three agree
    assign bus_raw = {sda_in, scl_in};

    for (genvar g = 0; g < 2; g++) begin : g_bus_sync
        logic [2:0] sync_r;
        logic       lvl_r;

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                sync_r <= 3'h7;
            end else begin
                sync_r <= {sync_r[1:0], bus_raw[g]};
            end
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                lvl_r <= 1'b1;
            end else if (sync_r[1] == sync_r[2]) begin
                lvl_r <= sync_r[2];
            end
        end

        assign bus_lvl[g] = lvl_r;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= bus_lvl[0];
            sda_d_r <= bus_lvl[1];
        end
    end

    assign scl_rise  = bus_lvl[0] && !scl_d_r;
    assign scl_fall  = !bus_lvl[0] && scl_d_r;
    assign start_det = bus_lvl[0] && scl_d_r && sda_d_r && !bus_lvl[1];
    assign stop_det  = bus_lvl[0] && scl_d_r && !sda_d_r && bus_lvl[1];
    assign byte_in   = {shift_r[6:0], bus_lvl[1]};

    // unmapped offsets read as zero rather than stalling the host
    always_comb begin
        case (ptr_r)
            bts_pkg::OFS_ONE_TGT:  rd_byte = buck_one_target_code_r;
            bts_pkg::OFS_ZERO_DVS: rd_byte = buck_zero_scaling_code_r;
            bts_pkg::OFS_ONE_DVS:  rd_byte = buck_one_scaling_code_r;
            default:               rd_byte = bts_pkg::READ_UNMAPPED;
        endcase
    end

    // serial engine: address, sub-address pointer, then data bytes with auto-increment
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r     <= bts_pkg::ST_IDLE;
            bit_cnt_r   <= 3'h0;
            shift_r     <= 8'h00;
            ptr_r       <= 8'h00;
            rw_r        <= 1'b0;
            ack_go_r    <= 1'b0;
            ack_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
            wr_en_r     <= 1'b0;
            wr_addr_r   <= 8'h00;
            wr_data_r   <= 8'h00;
        end else begin
            wr_en_r <= 1'b0;
            if (start_det) begin
                state_r     <= bts_pkg::ST_ADDR;
                bit_cnt_r   <= 3'h0;
                ack_go_r    <= 1'b0;
                ack_phase_r <= 1'b0;
                sda_oe_r    <= 1'b0;
            end else if (stop_det) begin
                state_r     <= bts_pkg::ST_IDLE;
                ack_go_r    <= 1'b0;
                ack_phase_r <= 1'b0;
                sda_oe_r    <= 1'b0;
            end else if (scl_rise && !ack_phase_r) begin
                case (state_r)
                    bts_pkg::ST_ADDR, bts_pkg::ST_SUB, bts_pkg::ST_WR: begin
                        shift_r   <= byte_in;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            if (state_r == bts_pkg::ST_ADDR) begin
                                if (byte_in[7:1] == DEV_ADDR) begin
                                    ack_go_r <= 1'b1;
                                    rw_r     <= byte_in[0];
                                end else begin
                                    state_r <= bts_pkg::ST_IDLE;
                                end
                            end else if (state_r == bts_pkg::ST_SUB) begin
                                ack_go_r <= 1'b1;
                                ptr_r    <= byte_in;
                            end else begin
                                ack_go_r  <= 1'b1;
                                wr_en_r   <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= byte_in;
                                ptr_r     <= ptr_r + 8'h01;
                            end
                        end
                    end
                    bts_pkg::ST_RD: begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            ack_go_r <= 1'b1;
                        end
                    end
                    default: begin
                        bit_cnt_r <= 3'h0;
                    end
                endcase
            end else if (scl_rise) begin
                // host acknowledge of a read byte: high ends the read
                if (state_r == bts_pkg::ST_RD && bus_lvl[1]) begin
                    state_r     <= bts_pkg::ST_IDLE;
                    ack_phase_r <= 1'b0;
                end
            end else if (scl_fall) begin
                if (ack_go_r) begin
                    ack_go_r    <= 1'b0;
                    ack_phase_r <= 1'b1;
                    sda_oe_r    <= (state_r != bts_pkg::ST_RD);
                end else if (ack_phase_r) begin
                    ack_phase_r <= 1'b0;
                    bit_cnt_r   <= 3'h0;
                    if (state_r == bts_pkg::ST_RD || (state_r == bts_pkg::ST_ADDR && rw_r)) begin
                        state_r  <= bts_pkg::ST_RD;
                        shift_r  <= rd_byte;
                        sda_oe_r <= !rd_byte[7];
                        ptr_r    <= ptr_r + 8'h01;
                    end else begin
                        sda_oe_r <= 1'b0;
                        state_r  <= (state_r == bts_pkg::ST_ADDR) ? bts_pkg::ST_SUB
                                                                 : bts_pkg::ST_WR;
                    end
                end else if (state_r == bts_pkg::ST_RD) begin
                    shift_r  <= {shift_r[6:0], 1'b0};
                    sda_oe_r <= !shift_r[6];
                end
            end
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sda_out_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;
        end
    end

    assign sda_out = sda_out_r;
    assign sda_oe  = sda_oe_r;

    // fuse bits are caught at every reset so a shutdown reloads them too
    always_ff @(posedge ref_clk) begin
        if (reset || global_shutdown) begin
            buck_one_target_code_r <= {1'b0, otp_buck_one_bits, 2'b00};
        end else if (wr_en_r && wr_addr_r == bts_pkg::OFS_ONE_TGT
                     && wr_data_r <= bts_pkg::ONE_CODE_MAX) begin
            buck_one_target_code_r <= wr_data_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || global_shutdown) begin
            buck_zero_scaling_code_r <= bts_pkg::RST_ZERO_DVS;
        end else if (wr_en_r && wr_addr_r == bts_pkg::OFS_ZERO_DVS
                     && wr_data_r <= bts_pkg::ZERO_CODE_MAX) begin
            buck_zero_scaling_code_r <= wr_data_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || global_shutdown) begin
            buck_one_scaling_code_r <= bts_pkg::RST_ONE_DVS;
        end else if (wr_en_r && wr_addr_r == bts_pkg::OFS_ONE_DVS
                     && wr_data_r <= bts_pkg::ONE_CODE_MAX) begin
            buck_one_scaling_code_r <= wr_data_r;
        end
    end

    bts_sel_if zero_if ();
    bts_sel_if one_if ();

    assign zero_if.main_code  = buck_zero_target_code;
    assign zero_if.alt_code   = buck_zero_scaling_code_r;
    assign zero_if.alt_enable = pin_five_alternate_enable;
    assign zero_if.polarity   = pin_five_polarity_select;
    assign zero_if.pin_raw    = general_pin_five;

    // the second regulator falls back to its own main code, not the first one's
    assign one_if.main_code   = buck_one_target_code_r;
    assign one_if.alt_code    = buck_one_scaling_code_r;
    assign one_if.alt_enable  = pin_six_alternate_enable;
    assign one_if.polarity    = pin_six_polarity_select;
    assign one_if.pin_raw     = general_pin_six;

    bts_dvs_select u_zero_sel (
        .ref_clk (ref_clk),
        .reset   (reset),
        .sel     (zero_if.sel)
    );

    bts_dvs_select u_one_sel (
        .ref_clk (ref_clk),
        .reset   (reset),
        .sel     (one_if.sel)
    );

    assign buck_zero_active_code    = zero_if.target_code;
    assign buck_one_active_code     = one_if.target_code;
    assign buck_zero_scaling_active = zero_if.scaling_active;
    assign buck_one_scaling_active  = one_if.scaling_active;
    assign buck_zero_code_reserved  = zero_if.code_reserved;
    assign buck_one_code_reserved   = one_if.code_reserved;
    assign buck_zero_target_uv      = zero_if.target_uv;
    assign buck_one_target_uv       = one_if.target_uv;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_one_target_store: assert property (
        wr_en_r && wr_addr_r == 8'h17 && wr_data_r <= 8'h4C && !global_shutdown
        |=> buck_one_target_code_r == $past(wr_data_r)
    ) else $error("accepted write to 0x17 not stored");

    a_one_code_reject: assert property (
        wr_en_r && wr_data_r > 8'h4C && !global_shutdown
        |=> $stable(buck_one_target_code_r) && $stable(buck_one_scaling_code_r)
    ) else $error("reserved code written to second regulator");

    a_zero_scale_store: assert property (
        wr_en_r && wr_addr_r == 8'h1B && wr_data_r <= 8'h40 && !global_shutdown
        |=> buck_zero_scaling_code_r == $past(wr_data_r)
    ) else $error("accepted write to 0x1B not stored");

    a_zero_scale_reject: assert property (
        wr_en_r && wr_data_r > 8'h40 && !global_shutdown
        |=> $stable(buck_zero_scaling_code_r)
    ) else $error("reserved code written to first regulator");

    a_one_scale_store: assert property (
        wr_en_r && wr_addr_r == 8'h1C && wr_data_r <= 8'h4C && !global_shutdown
        |=> buck_one_scaling_code_r == $past(wr_data_r)
    ) else $error("accepted write to 0x1C not stored");

    a_shutdown_restore: assert property (
        global_shutdown
        |=> buck_zero_scaling_code_r == 8'h20 && buck_one_scaling_code_r == 8'h10
            && buck_one_target_code_r == {1'b0, $past(otp_buck_one_bits), 2'b00}
    ) else $error("shutdown did not restore register values");

    a_write_from_bus: assert property (
        wr_en_r |-> $past(state_r) == bts_pkg::ST_WR && $past(scl_rise)
    ) else $error("register write without bus data byte");

endmodule : bts_target_select

// File: tb/bts_i2c_host.sv
// partner: i2c controller that reaches the register bank
module bts_i2c_host (
    input  wire logic ref_clk,
    input  wire logic sda_dev_oe,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_low_r;
    // pull-up on the wire: high unless someone pulls it low
    assign sda = !(host_low_r || sda_dev_oe);
    initial begin
        scl = 1'b1;
        host_low_r = 1'b0;
    end
    // half period of 8 cycles keeps setup and hold above the filter delay
    task automatic hp();
        repeat (8) @(negedge ref_clk);
    endtask : hp
    task automatic start();
        host_low_r = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        host_low_r = 1'b1;
        hp();
        scl = 1'b0;
        hp();
    endtask : start
    task automatic stop();
        host_low_r = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        host_low_r = 1'b0;
        hp();
    endtask : stop
    task automatic bit_x(input logic b, output logic r);
        host_low_r = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        hp();
        scl = 1'b0;
        hp();
    endtask : bit_x
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(ack_in, ack);
    endtask : xfer
endmodule : bts_i2c_host

// File: tb/buck_voltage_target_select_tb.sv
// testbench: register access, scaling selection and shutdown of the buck target selector
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module buck_voltage_target_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, reset = 1, global_shutdown = 0, scl, sda, sda_out, sda_oe;
    logic [4:0]  otp = 5'h15;
    logic [7:0]  main0 = 8'h30;
    logic        en5 = 0, pol5 = 0, en6 = 0, pol6 = 0, pin5 = 0, pin6 = 0;
    logic [7:0]  act0, act1, q;
    logic        sc0, sc1, rs0, rs1, ack;
    logic [21:0] uv0, uv1;
    logic [7:0]  regs [3];
    logic [7:0]  ofs_tbl [3] = '{8'h17, 8'h1B, 8'h1C};
    logic [7:0]  corner [6] = '{8'h4D, 8'h41, 8'h4C, 8'h01, 8'h40, 8'hFF};
    int          error_cnt = 0, checks = 0;
    always #10 ref_clk = ~ref_clk;
    bts_target_select bts_target_select_inst (.ref_clk(ref_clk), .reset(reset),
        .global_shutdown(global_shutdown), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .otp_buck_one_bits(otp), .buck_zero_target_code(main0),
        .pin_five_alternate_enable(en5), .pin_five_polarity_select(pol5),
        .pin_six_alternate_enable(en6), .pin_six_polarity_select(pol6),
        .general_pin_five(pin5), .general_pin_six(pin6), .buck_zero_active_code(act0),
        .buck_one_active_code(act1), .buck_zero_scaling_active(sc0),
        .buck_one_scaling_active(sc1), .buck_zero_code_reserved(rs0),
        .buck_one_code_reserved(rs1), .buck_zero_target_uv(uv0), .buck_one_target_uv(uv1));
    bts_i2c_host bts_i2c_host_inst (.ref_clk(ref_clk), .sda_dev_oe(sda_oe), .scl(scl),
        .sda(sda));
    function automatic logic [21:0] exp_uv(input logic [7:0] c);
        return (c < 8'h02) ? 22'h0 : 22'(625000 + (int'(c) - 2) * 12500);
    endfunction : exp_uv
    // reserved codes leave the old value in place; the first regulator has the lower ceiling
    function automatic logic [7:0] exp_wr(input int k, input logic [7:0] old, d);
        return (d > ((k == 1) ? 8'h40 : 8'h4C)) ? old : d;
    endfunction : exp_wr
    task automatic hdr(input logic [7:0] ofs);
        bts_i2c_host_inst.start();
        bts_i2c_host_inst.xfer({bts_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, q, ack);
        `CHK(ack, 1'b0)
        `CHK(sda_out, 1'b0)
        bts_i2c_host_inst.xfer(ofs, 1'b1, q, ack);
    endtask : hdr
    task automatic wr(input logic [7:0] ofs, d);
        hdr(ofs);
        bts_i2c_host_inst.xfer(d, 1'b1, q, ack);
        bts_i2c_host_inst.stop();
    endtask : wr
    task automatic rd(input logic [7:0] ofs, exp);
        hdr(ofs);
        bts_i2c_host_inst.start();
        bts_i2c_host_inst.xfer({bts_pkg::I2C_DEV_ADDR, 1'b1}, 1'b1, q, ack);
        bts_i2c_host_inst.xfer(8'hFF, 1'b1, q, ack);
        bts_i2c_host_inst.stop();
        `CHK(q, exp)
    endtask : rd
    task automatic sel_chk();
        logic       a0, a1;
        logic [7:0] c0, c1;
        repeat (10) @(negedge ref_clk);
        a0 = en5 && (pin5 ^ pol5);
        a1 = en6 && (pin6 ^ pol6);
        c0 = a0 ? regs[1] : main0;
        c1 = a1 ? regs[2] : regs[0];
        `CHK(act0, c0)
        `CHK(act1, c1)
        `CHK({sc0, sc1}, {a0, a1})
        `CHK({rs0, rs1}, {c0 < 8'h02, c1 < 8'h02})
        `CHK({uv0, uv1}, {exp_uv(c0), exp_uv(c1)})
    endtask : sel_chk
    task automatic close_out();
        $display("mismatches %0d of %0d comparisons", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // about 35000 cycles are needed; the margin covers slow filtering
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        close_out();
    end
    initial begin
        logic [7:0] d;
        int         k;
        void'($urandom(39949));
        regs = '{{1'b0, otp, 2'b00}, 8'h20, 8'h10};
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        repeat (6) @(negedge ref_clk);
        for (k = 0; k < 3; k++) rd(ofs_tbl[k], regs[k]);
        for (int i = 0; i < 12; i++) begin
            k = i % 3;
            d = (i < 6) ? corner[i] : 8'($urandom_range(0, 95));
            wr(ofs_tbl[k], d);
            regs[k] = exp_wr(k, regs[k], d);
            rd(ofs_tbl[k], regs[k]);
            main0 = 8'($urandom_range(0, 64));
            {en5, pol5, pin5, en6, pol6, pin6} = 6'($urandom);
            sel_chk();
        end
        // every enable, polarity and pin level, the two regulators in opposite phase
        for (int j = 0; j < 8; j++) begin
            {en5, pol5, pin5} = 3'(j);
            {en6, pol6, pin6} = ~3'(j);
            // main code walks 0..7: both reserved codes, then adjacent ladder steps
            main0 = 8'(j);
            sel_chk();
        end
        global_shutdown = 1'b1;
        @(negedge ref_clk);
        global_shutdown = 1'b0;
        regs = '{{1'b0, otp, 2'b00}, 8'h20, 8'h10};
        for (k = 0; k < 3; k++) rd(ofs_tbl[k], regs[k]);
        sel_chk();
        bts_i2c_host_inst.start();
        bts_i2c_host_inst.xfer({bts_pkg::I2C_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
        `CHK(ack, 1'b1)
        bts_i2c_host_inst.stop();
        rd(8'h20, bts_pkg::READ_UNMAPPED);
        close_out();
    end
endmodule : buck_voltage_target_select_tb
